// *** include/err_count_if.sv ***
// Carrier between the register bank and its error event counter.
// Assumes both ends run on the same core clock.
interface err_count_if;
    logic [ser_regs_pkg::EVENT_MASK_W-1:0] events;
    logic [ser_regs_pkg::EVENT_MASK_W-1:0] mask;
    logic clear;
    logic [ser_regs_pkg::ERR_COUNT_W-1:0] count;

    modport src (output events, output mask, output clear, input count);
    modport cnt (input events, input mask, input clear, output count);
endinterface

// *** include/ser_regs_pkg.sv ***
// Constants of the serializer event and status register bank.
// Assumes one 25 MHz core clock and a byte-wide register port behind the configuration port.
// Function
// - FIFO over/underflow, data and clock loss are error events, each maskable.
// - Mask bit 4 set stops counting PLL clock errors; clear counts them.
// - Mask bit 3 set ignores FIFO errors; clear counts them.
// - Mask bit 2 set ignores input clock detect errors; clear counts them.
// - Mask bit 1 set ignores clock loss errors; clear counts them.
// - Mask bit 0 set ignores data loss errors; clear counts them.
// - Status bit 5 reads one while a clock is present on the input pair.
// - Status bits 4:0 read one per lane while data is present.
// - Event status bit 3 reads one while the input clock is detected.
// - Event status bit 2 reads one while the PLL is locked.
// - Bit 6 set reverses serialization order; reset value keeps normal order.
// - Delay field 7:5 picks input clock delay, about 125ps a step, reset 011.
// - Bypass bit 7 set skips the programmable clock delay; reset applies it.
package ser_regs_pkg;

    // ========================================
    // Register offsets
    localparam logic [7:0] OFF_CLOCK_DELAY_BYPASS = 8'h24;
    localparam logic [7:0] OFF_EVENT_MASK = 8'h27;
    localparam logic [7:0] OFF_LVDS_OPERATION_CTRL = 8'h28;
    localparam logic [7:0] OFF_SIGNAL_LOSS_STATUS = 8'h29;
    localparam logic [7:0] OFF_EVENT_STATUS = 8'h2a;
    localparam logic [7:0] OFF_BIT_ORDER_CTRL = 8'h2e;
    localparam logic [7:0] OFF_INPUT_CLOCK_DELAY = 8'h30;
    localparam logic [7:0] OFF_ERROR_COUNT = 8'h31;

    // ========================================
    // Field positions
    localparam int BIT_DATA_LOSS_MASK = 0;
    localparam int BIT_CLOCK_LOSS_MASK = 1;
    localparam int BIT_CLK_DETECT_MASK = 2;
    localparam int BIT_FIFO_MASK = 3;
    localparam int BIT_PLL_CLK_MASK = 4;
    localparam int EVENT_MASK_W = 5;
    localparam int BIT_CLOCK_PRESENCE = 5;
    localparam int LANE_COUNT = 5;
    localparam int BIT_CLK_DETECTED = 3;
    localparam int BIT_PLL_LOCK = 2;
    localparam int BIT_REVERSE_ORDER = 6;
    localparam int BIT_DELAY_BYPASS = 7;
    localparam int DELAY_LSB = 5;
    localparam int DELAY_W = 3;
    localparam int LVDS_OP_W = 2;
    localparam int ERR_COUNT_W = 8;

    // ========================================
    // Reset values and timing
    localparam logic [4:0] EVENT_MASK_RST = 5'h00;
    localparam logic [1:0] LVDS_OP_RST = 2'h0;
    localparam logic REVERSE_ORDER_RST = 1'b0;
    localparam logic DELAY_BYPASS_RST = 1'b0;
    localparam logic [2:0] DELAY_SEL_RST = 3'h3;
    localparam logic [7:0] ERR_COUNT_RST = 8'h00;
    localparam int DELAY_STEP_PS = 125;

endpackage

// *** tb/host_model.sv ***
// Host side model of the byte register port.
// Assumes the same core clock as the register bank.
module host_model (
    // Clock
    input wire logic mclk_i,
    // Register port
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end
    // ========================================
    // Access tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge mclk_i);
        reg_wr_o <= 1'b0;
        reg_wdata_o <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge mclk_i);
        reg_rd_o <= 1'b0;
        @(posedge mclk_i);
        d = reg_rvalid_i ? reg_rdata_i : 8'hxx;
    endtask
endmodule

// *** tb/ser_regs_asserts.sv ***
// Port checker of the serializer event and status register bank.
// Assumes one core clock and a synchronous active-low reset.
module ser_regs_asserts (
    input wire logic mclk_i, rst_n_i, reg_wr_i, reg_rd_i, reg_rvalid_o,
    input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, error_count_o,
    input wire logic [4:0] lane_data_presence_i,
    input wire logic clock_presence_i, input_clock_detected_i, pll_lock_i,
    input wire logic pll_clock_error_i, fifo_overflow_i, fifo_underflow_i,
    input wire logic reverse_bit_order_o, clock_delay_bypass_o,
    input wire logic [2:0] input_clock_delay_sel_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // ========================================
    // Mask copy
    logic [4:0] mask_q, mask_d;
    always_comb begin
        mask_d = mask_q;
        if (reg_wr_i && reg_addr_i == 8'h27) begin
            mask_d = reg_wdata_i[4:0];
        end
    end
    always_ff @(posedge mclk_i) begin
        mask_q <= rst_n_i ? mask_d : 5'h00;
    end
    // ========================================
    // Sequences
    sequence s_wr(a);
        reg_wr_i && reg_addr_i == a;
    endsequence
    sequence s_rd(a);
        reg_rd_i && reg_addr_i == a;
    endsequence
    sequence s_quiet;
        !(fifo_overflow_i || fifo_underflow_i || pll_clock_error_i)
        && $stable(lane_data_presence_i) && $stable(clock_presence_i)
        && $stable(input_clock_detected_i) && !(reg_wr_i && reg_addr_i == 8'h31);
    endsequence
    // ========================================
    // Assertions
    a_loss_status_read: assert property (s_rd(8'h29) |=> reg_rvalid_o &&
        reg_rdata_o == {2'b00, $past(clock_presence_i), $past(lane_data_presence_i)})
        else $error("loss status read wrong");
    a_event_status_read: assert property (s_rd(8'h2a) |=> reg_rvalid_o &&
        reg_rdata_o == {4'h0, $past(input_clock_detected_i), $past(pll_lock_i), 2'b00})
        else $error("event status read wrong");
    a_mask_reserved_zero: assert property (s_rd(8'h27) |=> reg_rdata_o[7:5] == 3'h0)
        else $error("mask reserved bits not zero");
    a_reverse_from_write: assert property (s_wr(8'h2e) |=>
        {1'b0, reverse_bit_order_o, 6'h00} == ($past(reg_wdata_i) & 8'h40))
        else $error("bit order output wrong");
    a_delay_from_write: assert property (s_wr(8'h30) |=>
        {input_clock_delay_sel_o, 5'h00} == ($past(reg_wdata_i) & 8'he0))
        else $error("delay select output wrong");
    a_bypass_from_write: assert property (s_wr(8'h24) |=>
        {clock_delay_bypass_o, 7'h00} == ($past(reg_wdata_i) & 8'h80))
        else $error("bypass output wrong");
    a_count_quiet_hold: assert property (s_quiet |=> $stable(error_count_o))
        else $error("count moved without event");
    a_count_saturates: assert property (error_count_o == 8'hff &&
        !(reg_wr_i && reg_addr_i == 8'h31) |=> error_count_o == 8'hff)
        else $error("count wrapped");
    a_pll_err_counts: assert property (pll_clock_error_i && !mask_q[4] &&
        error_count_o != 8'hff && !(reg_wr_i && reg_addr_i == 8'h31)
        |=> error_count_o > $past(error_count_o))
        else $error("clock error not counted");
    a_fifo_err_counts: assert property ((fifo_overflow_i || fifo_underflow_i) &&
        !mask_q[3] && error_count_o != 8'hff && !(reg_wr_i && reg_addr_i == 8'h31)
        |=> error_count_o > $past(error_count_o))
        else $error("fifo error not counted");
endmodule

bind serializer_event_status_regs ser_regs_asserts u_chk (.mclk_i, .rst_n_i, .reg_wr_i,
    .reg_rd_i, .reg_rvalid_o, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .error_count_o,
    .lane_data_presence_i, .clock_presence_i, .input_clock_detected_i, .pll_lock_i,
    .pll_clock_error_i, .fifo_overflow_i, .fifo_underflow_i, .reverse_bit_order_o,
    .clock_delay_bypass_o, .input_clock_delay_sel_o);

// *** tb/tb.sv ***
// Self-checking bench of the serializer event and status register bank.
// Assumes the host model drives the register port; the bench drives status.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [10:0] sts = 11'h000;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, error_count_o, c;
    logic reg_wr_i, reg_rd_i, reg_rvalid_o, reverse_bit_order_o, clock_delay_bypass_o;
    logic [2:0] input_clock_delay_sel_o;
    logic [1:0] lvds_operation_o;
    int error_cnt = 0;
    int check_count = 0;
    logic [7:0] rw_addr [5] = '{8'h27, 8'h28, 8'h2e, 8'h30, 8'h24};
    logic [7:0] rw_rst [5] = '{8'h00, 8'h00, 8'h00, 8'h60, 8'h00};
    logic [7:0] rw_full [5] = '{8'h1f, 8'h03, 8'h40, 8'he0, 8'h80};
    logic [10:0] pat [5] = '{11'h040, 11'h020, 11'h010, 11'h003, 11'h004};
    initial begin
        forever #20 mclk_i = ~mclk_i;
    end
    host_model u_host (.mclk_i, .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
        .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o),
        .reg_rvalid_i(reg_rvalid_o));
    serializer_event_status_regs u_dut (.mclk_i, .rst_n_i, .reg_addr_i, .reg_wr_i,
        .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
        .lane_data_presence_i(sts[10:6]), .clock_presence_i(sts[5]),
        .input_clock_detected_i(sts[4]), .pll_lock_i(sts[3]), .pll_clock_error_i(sts[2]),
        .fifo_overflow_i(sts[1]), .fifo_underflow_i(sts[0]), .reverse_bit_order_o,
        .input_clock_delay_sel_o, .clock_delay_bypass_o, .lvds_operation_o, .error_count_o);
    // ========================================
    // Tasks
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.rd(a, d);
        chk($sformatf("reg %h", a), d, exp);
    endtask
    task automatic fire(input int k);
        @(posedge mclk_i);
        sts <= pat[k];
        @(posedge mclk_i);
        sts <= 11'h000;
        repeat (2) @(posedge mclk_i);
    endtask
    task automatic complete_run;
        if (error_cnt == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge mclk_i);
        error_cnt++;
        complete_run;
    end
    // ========================================
    // Tests
    initial begin
        repeat (4) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 5; i++) rchk(rw_addr[i], rw_rst[i]);
        rchk(8'h31, 8'h00);
        for (int i = 0; i < 5; i++) begin
            u_host.wr(rw_addr[i], 8'hff);
            rchk(rw_addr[i], rw_full[i]);
        end
        chk("ports", {reverse_bit_order_o, input_clock_delay_sel_o, clock_delay_bypass_o,
            lvds_operation_o, 1'b0}, 8'hfe);
        u_host.wr(8'h30, 8'h20);
        u_host.wr(8'h24, 8'h00);
        u_host.wr(8'h2e, 8'h00);
        @(posedge mclk_i);
        chk("ports", {reverse_bit_order_o, input_clock_delay_sel_o, clock_delay_bypass_o,
            lvds_operation_o, 1'b0}, 8'h16);
        u_host.wr(8'h2b, 8'hff);
        rchk(8'h2b, 8'h00);
        u_host.wr(8'h31, 8'h00);
        c = 8'h00;
        for (int k = 0; k < 5; k++) begin
            u_host.wr(8'h27, 8'h01 << k);
            fire(k);
            rchk(8'h31, c);
            u_host.wr(8'h27, 8'h1f ^ (8'h01 << k));
            fire(k);
            c++;
            rchk(8'h31, c);
        end
        u_host.wr(8'h27, 8'h00);
        sts <= 11'h002;
        repeat (260) @(posedge mclk_i);
        sts <= 11'h000;
        rchk(8'h31, 8'hff);
        chk("count port", error_count_o, 8'hff);
        u_host.wr(8'h31, 8'h00);
        rchk(8'h31, 8'h00);
        sts <= {5'h15, 6'h30};
        rchk(8'h29, 8'h35);
        rchk(8'h2a, 8'h08);
        sts <= {5'h0a, 6'h08};
        u_host.wr(8'h29, 8'hff);
        rchk(8'h29, 8'h0a);
        rchk(8'h2a, 8'h04);
        complete_run;
    end
endmodule

// *** verilog/err_event_counter.sv ***
// Saturating counter of unmasked error events.
// Assumes event bits are one-cycle pulses; several in one cycle all count.
module err_event_counter (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Events, mask, clear and count
    err_count_if.cnt ec
);

    // ========================================
    // Saturating add
    function automatic logic [ser_regs_pkg::ERR_COUNT_W-1:0] sat_add(
        input logic [ser_regs_pkg::ERR_COUNT_W-1:0] base,
        input logic [ser_regs_pkg::EVENT_MASK_W-1:0] hits
    );
        logic [ser_regs_pkg::ERR_COUNT_W:0] sum;
        sum = {1'b0, base};
        for (int i = 0; i < ser_regs_pkg::EVENT_MASK_W; i++) begin
            sum = sum + {{ser_regs_pkg::ERR_COUNT_W{1'b0}}, hits[i]};
        end
        if (sum[ser_regs_pkg::ERR_COUNT_W]) begin
            sat_add = '1;
        end else begin
            sat_add = sum[ser_regs_pkg::ERR_COUNT_W-1:0];
        end
    endfunction

    logic [ser_regs_pkg::ERR_COUNT_W-1:0] count_q;
    logic [ser_regs_pkg::ERR_COUNT_W-1:0] count_d;
    logic [ser_regs_pkg::EVENT_MASK_W-1:0] hits;

    // ========================================
    // Next count
    always_comb begin
        hits = ec.events & ~ec.mask;
        if (ec.clear) begin
            count_d = sat_add(ser_regs_pkg::ERR_COUNT_RST, hits);
        end else begin
            count_d = sat_add(count_q, hits);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            count_q <= ser_regs_pkg::ERR_COUNT_RST;
        end else begin
            count_q <= count_d;
        end
    end

    assign ec.count = count_q;

endmodule

// *** verilog/serializer_event_status_regs.sv ***
// Event mask, signal loss and event status, bit order and clock delay registers.
// Assumes a byte register port from the configuration engine and synchronous status inputs.
module serializer_event_status_regs (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Status sources
    input wire logic [4:0] lane_data_presence_i,
    input wire logic clock_presence_i,
    input wire logic input_clock_detected_i,
    input wire logic pll_lock_i,
    input wire logic pll_clock_error_i,
    input wire logic fifo_overflow_i,
    input wire logic fifo_underflow_i,
    // Datapath controls and error count
    output logic reverse_bit_order_o,
    output logic [2:0] input_clock_delay_sel_o,
    output logic clock_delay_bypass_o,
    output logic [1:0] lvds_operation_o,
    output logic [7:0] error_count_o
);

    // ========================================
    // Control registers
    logic [4:0] event_mask_q;
    logic [4:0] event_mask_d;
    logic [1:0] lvds_op_q;
    logic [1:0] lvds_op_d;
    logic reverse_q;
    logic reverse_d;
    logic bypass_q;
    logic bypass_d;
    logic [2:0] delay_q;
    logic [2:0] delay_d;

    // ========================================
    // Address decode
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    logic wr_mask;
    logic wr_lvds;
    logic wr_order;
    logic wr_bypass;
    logic wr_delay;
    logic wr_clear;

    assign wr_mask = reg_wr_i && hit(reg_addr_i, ser_regs_pkg::OFF_EVENT_MASK);
    assign wr_lvds = reg_wr_i && hit(reg_addr_i, ser_regs_pkg::OFF_LVDS_OPERATION_CTRL);
    assign wr_order = reg_wr_i && hit(reg_addr_i, ser_regs_pkg::OFF_BIT_ORDER_CTRL);
    assign wr_bypass = reg_wr_i && hit(reg_addr_i, ser_regs_pkg::OFF_CLOCK_DELAY_BYPASS);
    assign wr_delay = reg_wr_i && hit(reg_addr_i, ser_regs_pkg::OFF_INPUT_CLOCK_DELAY);
    assign wr_clear = reg_wr_i && hit(reg_addr_i, ser_regs_pkg::OFF_ERROR_COUNT);

    // ========================================
    // Register next values
    always_comb begin
        event_mask_d = event_mask_q;
        lvds_op_d = lvds_op_q;
        reverse_d = reverse_q;
        bypass_d = bypass_q;
        delay_d = delay_q;
        if (wr_mask) begin
            event_mask_d = reg_wdata_i[4:0];
        end
        if (wr_lvds) begin
            lvds_op_d = reg_wdata_i[1:0];
        end
        if (wr_order) begin
            reverse_d = reg_wdata_i[ser_regs_pkg::BIT_REVERSE_ORDER];
        end
        if (wr_bypass) begin
            bypass_d = reg_wdata_i[ser_regs_pkg::BIT_DELAY_BYPASS];
        end
        if (wr_delay) begin
            delay_d = reg_wdata_i[ser_regs_pkg::DELAY_LSB +: ser_regs_pkg::DELAY_W];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            event_mask_q <= ser_regs_pkg::EVENT_MASK_RST;
            lvds_op_q <= ser_regs_pkg::LVDS_OP_RST;
            reverse_q <= ser_regs_pkg::REVERSE_ORDER_RST;
            bypass_q <= ser_regs_pkg::DELAY_BYPASS_RST;
            delay_q <= ser_regs_pkg::DELAY_SEL_RST;
        end else begin
            event_mask_q <= event_mask_d;
            lvds_op_q <= lvds_op_d;
            reverse_q <= reverse_d;
            bypass_q <= bypass_d;
            delay_q <= delay_d;
        end
    end

    // ========================================
    // Datapath outputs
    assign reverse_bit_order_o = reverse_q;
    assign input_clock_delay_sel_o = delay_q;
    assign clock_delay_bypass_o = bypass_q;
    assign lvds_operation_o = lvds_op_q;

    // ========================================
    // Error event detection
    logic [4:0] lanes_prev_q;
    logic [4:0] lanes_prev_d;
    logic clk_prev_q;
    logic clk_prev_d;
    logic det_prev_q;
    logic det_prev_d;
    logic [4:0] events;

    function automatic logic fell(input logic prev, input logic cur);
        fell = prev && !cur;
    endfunction

    always_comb begin
        lanes_prev_d = lane_data_presence_i;
        clk_prev_d = clock_presence_i;
        det_prev_d = input_clock_detected_i;
        events = '0;
        events[ser_regs_pkg::BIT_DATA_LOSS_MASK] =
            |(lanes_prev_q & ~lane_data_presence_i);
        events[ser_regs_pkg::BIT_CLOCK_LOSS_MASK] = fell(clk_prev_q, clock_presence_i);
        events[ser_regs_pkg::BIT_CLK_DETECT_MASK] =
            fell(det_prev_q, input_clock_detected_i);
        events[ser_regs_pkg::BIT_FIFO_MASK] = fifo_overflow_i | fifo_underflow_i;
        events[ser_regs_pkg::BIT_PLL_CLK_MASK] = pll_clock_error_i;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            lanes_prev_q <= 5'h00;
            clk_prev_q <= 1'b0;
            det_prev_q <= 1'b0;
        end else begin
            lanes_prev_q <= lanes_prev_d;
            clk_prev_q <= clk_prev_d;
            det_prev_q <= det_prev_d;
        end
    end

    // ========================================
    // Error counter
    err_count_if ec ();

    assign ec.events = events;
    assign ec.mask = event_mask_q;
    assign ec.clear = wr_clear;
    assign error_count_o = ec.count;

    err_event_counter u_counter (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .ec(ec)
    );

    // ========================================
    // Read path
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;

    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = reg_rd_i;
        if (reg_rd_i) begin
            rdata_d = 8'h00;
            unique case (reg_addr_i)
                ser_regs_pkg::OFF_CLOCK_DELAY_BYPASS: begin
                    rdata_d[ser_regs_pkg::BIT_DELAY_BYPASS] = bypass_q;
                end
                ser_regs_pkg::OFF_EVENT_MASK: begin
                    rdata_d[4:0] = event_mask_q;
                end
                ser_regs_pkg::OFF_LVDS_OPERATION_CTRL: begin
                    rdata_d[1:0] = lvds_op_q;
                end
                ser_regs_pkg::OFF_SIGNAL_LOSS_STATUS: begin
                    rdata_d[ser_regs_pkg::BIT_CLOCK_PRESENCE] = clock_presence_i;
                    rdata_d[4:0] = lane_data_presence_i;
                end
                ser_regs_pkg::OFF_EVENT_STATUS: begin
                    rdata_d[ser_regs_pkg::BIT_CLK_DETECTED] = input_clock_detected_i;
                    rdata_d[ser_regs_pkg::BIT_PLL_LOCK] = pll_lock_i;
                end
                ser_regs_pkg::OFF_BIT_ORDER_CTRL: begin
                    rdata_d[ser_regs_pkg::BIT_REVERSE_ORDER] = reverse_q;
                end
                ser_regs_pkg::OFF_INPUT_CLOCK_DELAY: begin
                    rdata_d[ser_regs_pkg::DELAY_LSB +: ser_regs_pkg::DELAY_W] = delay_q;
                end
                ser_regs_pkg::OFF_ERROR_COUNT: begin
                    rdata_d = ec.count;
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign reg_rvalid_o = rvalid_q;

endmodule
